// File: pex_exception_entry.sv
// Exception entry sequencer: arbitration, banked link and saved status,
// status word forcing, vector fetch, abort handling and fault capture.
// Assumes the core holds at EXEC_START while EXC_BUSY_OUT is high and
// that every instruction entering the pipeline pulses FETCH_DONE_IN.
//
// Notes on behaviour
// - Normal interrupt entry fetches next from 0x18.
// - Aborts come from translation unit or external pin, sampled in memory cycles.
// - Prefetch abort only tags the instruction; flushed ones never trap.
// - Aborted single load or store still writes back its base.
// - Aborted swap leaves state untouched though the read may have happened.
// - Aborted block transfer completes, keeps base write-back, blocks later writes.
// - With translation on, abort captures status, domain and faulting address.
// - Abort saves address plus 4 or plus 8 and the status word.
// - Abort entry forces mode 10111 and sets interrupt disable.
// - Prefetch abort vectors to 0x0C, data abort to 0x10.
// - Late aborts only: base updates are never undone.
// - Software interrupt saves address plus 4 and status in supervisor bank.
// - Software interrupt forces mode 10011, sets I, fetches 0x08.
// - Unknown and coprocessor instructions trap, except internal register transfers.
// - Undefined entry saves plus 4, forces 11011, sets I, fetches 0x04.
// - Reset vector 0x00, fast interrupt 0x1C; 0x14 never used.
// - Priority: reset, data abort, fast, normal, prefetch, undefined or swi.
// - Data abort with enabled fast interrupt enters both, fast last.
// - While reset pin low, abandon work and idle on incrementing words.
// - On reset release copy counter and status into supervisor bank.
// - On reset release force supervisor mode and set both disables.
// - Normal interrupt saves next address plus 4, forces 10010, sets I.
// - Fast interrupt saves plus 4, forces 10001, sets both disables.
// - Interrupt pins delayed one cycle, tested at each instruction boundary.
// - First fetch from 0x00 about four cycles after reset pin rises.
`timescale 1ns/1ps

module pex_exception_entry #(
  parameter int PIPE_DEPTH = 2
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  // Device pins, active low
  input wire logic RESET_IN_N_IN,
  input wire logic FAST_INTERRUPT_IN_N_IN,
  input wire logic NORMAL_INTERRUPT_IN_N_IN,
  // Memory system
  input wire logic MEM_CYCLE_IN,
  input wire logic DATA_ACCESS_IN,
  input wire logic FETCH_DONE_IN,
  input wire logic MMU_ABORT_IN,
  input wire logic EXT_ABORT_IN,
  input wire logic TRANSLATE_EN_IN,
  input wire logic [pex_pkg::FS_W-1:0] FAULT_STATUS_IN,
  input wire logic [pex_pkg::DOMAIN_W-1:0] FAULT_DOMAIN_IN,
  input wire logic [31:0] FAULT_VADDR_IN,
  // Pipeline
  input wire logic FLUSH_IN,
  input wire logic EXEC_START_IN,
  input wire logic [31:0] INSTR_ADDR_IN,
  input wire logic [1:0] INSTR_CLASS_IN,
  input wire logic INSTR_UNKNOWN_IN,
  input wire logic INSTR_COPROC_IN,
  input wire logic COPROC_INTERNAL_XFER_IN,
  input wire logic SWI_INSTR_IN,
  // Status word write from software
  input wire logic CSR_WR_IN,
  input wire logic [31:0] CSR_WDATA_IN,
  // Sequencing outputs
  output logic EXC_BUSY_OUT,
  output logic VECTOR_FETCH_OUT,
  output logic [31:0] VECTOR_ADDR_OUT,
  output logic IDLE_CYCLE_OUT,
  output logic [31:0] IDLE_ADDR_OUT,
  output logic REG_WRITE_BLOCK_OUT,
  output logic BASE_WB_ALLOW_OUT,
  // Architectural state
  output logic [31:0] CURRENT_STATUS_OUT,
  output logic [31:0] SUPERVISOR_LINK_OUT,
  output logic [31:0] SUPERVISOR_SAVED_OUT,
  output logic [31:0] ABORT_LINK_OUT,
  output logic [31:0] ABORT_SAVED_OUT,
  output logic [31:0] UNDEFINED_LINK_OUT,
  output logic [31:0] UNDEFINED_SAVED_OUT,
  output logic [31:0] INTERRUPT_LINK_OUT,
  output logic [31:0] INTERRUPT_SAVED_OUT,
  output logic [31:0] FAST_LINK_OUT,
  output logic [31:0] FAST_SAVED_OUT,
  output logic [7:0] FAULT_STATUS_REG_OUT,
  output logic [31:0] FAULT_ADDRESS_REG_OUT
);

  typedef enum logic [1:0] {
    ST_RESET_HOLD, ST_RUN, ST_ENTRY, ST_VECT
  } pex_state_t;

  pex_state_t state_r;
  pex_pkg::pex_exc_t exc_r;
  pex_pkg::pex_exc_t exc_sel;
  logic rst_sync1_r;
  logic rst_pin_r;
  logic fiq_req_r;
  logic irq_req_r;
  logic fiq_go;
  logic irq_go;
  logic [31:0] csr_r;
  logic [31:0] link_r [pex_pkg::NUM_BANKS];
  logic [31:0] saved_r [pex_pkg::NUM_BANKS];
  logic [31:0] link_src_r;
  logic [31:0] vec_addr_r;
  logic [31:0] idle_addr_r;
  logic [31:0] exec_addr_r;
  logic [31:0] dabt_addr_r;
  logic dabt_pend_r;
  logic cur_aborted_r;
  logic [PIPE_DEPTH-1:0] tag_r;
  logic [7:0] fsr_r;
  logic [31:0] far_r;
  logic abort_now;
  logic dabt_now;
  logic pabt_now;
  logic aborted;
  logic undef_instr;
  logic chain_fiq;
  logic take_exc;

  // ==========================================================
  // Pin sampling
  // Two-stage reset synchroniser
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      rst_sync1_r <= 1'b0;
      rst_pin_r <= 1'b0;
    end else begin
      rst_sync1_r <= RESET_IN_N_IN;
      rst_pin_r <= rst_sync1_r;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      fiq_req_r <= 1'b0;
      irq_req_r <= 1'b0;
    end else begin
      fiq_req_r <= ~FAST_INTERRUPT_IN_N_IN;
      irq_req_r <= ~NORMAL_INTERRUPT_IN_N_IN;
    end
  end

  // ==========================================================
  // Abort detection
  // Only memory cycles count
  assign abort_now = MEM_CYCLE_IN & (MMU_ABORT_IN | EXT_ABORT_IN);
  assign dabt_now = abort_now & DATA_ACCESS_IN;
  assign pabt_now = abort_now & ~DATA_ACCESS_IN;

  // Tag travels with the fetch; flush discards it
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN || !rst_pin_r) begin
      tag_r <= '0;
    end else if (FLUSH_IN) begin
      tag_r <= {{(PIPE_DEPTH-1){1'b0}}, FETCH_DONE_IN & pabt_now};
    end else if (FETCH_DONE_IN) begin
      tag_r <= {tag_r[PIPE_DEPTH-2:0], pabt_now};
    end
  end

  // Address of the instruction now executing
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      exec_addr_r <= '0;
    end else if (state_r == ST_RUN && EXEC_START_IN) begin
      exec_addr_r <= INSTR_ADDR_IN;
    end
  end

  // Pending data abort; a new abort wins over the clear at entry
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN || !rst_pin_r) begin
      dabt_pend_r <= 1'b0;
      dabt_addr_r <= '0;
    end else if (dabt_now) begin
      dabt_pend_r <= 1'b1;
      dabt_addr_r <= exec_addr_r;
    end else if (state_r == ST_ENTRY && exc_r == pex_pkg::EXC_DABT) begin
      dabt_pend_r <= 1'b0;
    end
  end

  // Aborted flag for the instruction in flight
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN || !rst_pin_r) begin
      cur_aborted_r <= 1'b0;
    end else if (dabt_now) begin
      cur_aborted_r <= 1'b1;
    end else if (EXEC_START_IN) begin
      cur_aborted_r <= 1'b0;
    end
  end

  // Base updates are never rolled back, only later writes blocked
  assign aborted = cur_aborted_r | dabt_now;
  // Swap discards every write, base included
  // Block transfer keeps base write-back, drops data and counter
  assign REG_WRITE_BLOCK_OUT = aborted &
                               (INSTR_CLASS_IN != pex_pkg::CLS_OTHER);
  assign BASE_WB_ALLOW_OUT = ~(aborted &
                               (INSTR_CLASS_IN == pex_pkg::CLS_SWAP));

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      fsr_r <= '0;
      far_r <= '0;
    end else if (abort_now && TRANSLATE_EN_IN) begin
      fsr_r <= {FAULT_DOMAIN_IN, FAULT_STATUS_IN};
      far_r <= FAULT_VADDR_IN;
    end
  end

  // ==========================================================
  // Arbitration
  // Coprocessor traps except internal register transfers
  assign undef_instr = INSTR_UNKNOWN_IN |
                       (INSTR_COPROC_IN & ~COPROC_INTERNAL_XFER_IN);
  assign fiq_go = fiq_req_r & ~csr_r[pex_pkg::CSR_F_BIT];
  assign irq_go = irq_req_r & ~csr_r[pex_pkg::CSR_I_BIT];

  always_comb begin
    exc_sel = pex_pkg::EXC_NONE;
    if (dabt_pend_r) begin
      exc_sel = pex_pkg::EXC_DABT;
    end else if (fiq_go) begin
      exc_sel = pex_pkg::EXC_FIQ;
    end else if (irq_go) begin
      exc_sel = pex_pkg::EXC_IRQ;
    end else if (tag_r[PIPE_DEPTH-1]) begin
      exc_sel = pex_pkg::EXC_PABT;
    end else if (undef_instr) begin
      exc_sel = pex_pkg::EXC_UND;
    end else if (SWI_INSTR_IN) begin
      exc_sel = pex_pkg::EXC_SWI;
    end
  end

  assign take_exc = state_r == ST_RUN && EXEC_START_IN &&
                    exc_sel != pex_pkg::EXC_NONE;
  // Fast interrupt still enabled after abort entry
  assign chain_fiq = state_r == ST_VECT && exc_r == pex_pkg::EXC_DABT &&
                     fiq_go;

  // ==========================================================
  // Sequencer
  // Low reset pin abandons anything in progress
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN || !rst_pin_r) begin
      state_r <= ST_RESET_HOLD;
    end else begin
      case (state_r)
        ST_RESET_HOLD: begin
          state_r <= ST_ENTRY;
        end
        ST_RUN: begin
          if (take_exc) begin
            state_r <= ST_ENTRY;
          end
        end
        ST_ENTRY: begin
          state_r <= ST_VECT;
        end
        ST_VECT: begin
          state_r <= chain_fiq ? ST_ENTRY : ST_RUN;
        end
        default: begin
          state_r <= ST_RESET_HOLD;
        end
      endcase
    end
  end

  // Exception being entered and the return address it saves
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      exc_r <= pex_pkg::EXC_RESET;
      link_src_r <= '0;
    end else if (state_r == ST_RESET_HOLD) begin
      // Counter value at release goes to supervisor link
      exc_r <= pex_pkg::EXC_RESET;
      link_src_r <= idle_addr_r;
    end else if (take_exc) begin
      exc_r <= exc_sel;
      // Data abort plus 8, all others plus 4
      if (exc_sel == pex_pkg::EXC_DABT) begin
        link_src_r <= dabt_addr_r + pex_pkg::LINK_ADD_DATA;
      end else begin
        link_src_r <= INSTR_ADDR_IN + pex_pkg::LINK_ADD_SHORT;
      end
    end else if (chain_fiq) begin
      // Fast return resumes the abort handler
      exc_r <= pex_pkg::EXC_FIQ;
      link_src_r <= pex_pkg::VEC_DABT + pex_pkg::LINK_ADD_SHORT;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      for (int b = 0; b < pex_pkg::NUM_BANKS; b++) begin
        link_r[b] <= '0;
        saved_r[b] <= '0;
      end
    end else if (state_r == ST_ENTRY) begin
      link_r[pex_pkg::pex_bank(exc_r)] <= link_src_r;
      saved_r[pex_pkg::pex_bank(exc_r)] <= csr_r;
    end
  end

  // Status word: entry forcing beats a software write
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      csr_r <= pex_pkg::CSR_RESET;
    end else if (state_r == ST_ENTRY) begin
      csr_r[pex_pkg::CSR_MODE_LSB +: pex_pkg::CSR_MODE_W] <=
        pex_pkg::pex_mode(exc_r);
      csr_r[pex_pkg::CSR_I_BIT] <= 1'b1;
      // Fast disable only for reset and fast entry
      if (exc_r == pex_pkg::EXC_FIQ || exc_r == pex_pkg::EXC_RESET) begin
        csr_r[pex_pkg::CSR_F_BIT] <= 1'b1;
      end
    end else if (state_r == ST_RUN && CSR_WR_IN) begin
      csr_r <= CSR_WDATA_IN;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      vec_addr_r <= pex_pkg::VEC_RESET;
    end else if (state_r == ST_ENTRY) begin
      vec_addr_r <= pex_pkg::pex_vector(exc_r);
    end
  end

  // Idle cycles walk word addresses while held
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      idle_addr_r <= '0;
    end else if (state_r == ST_RESET_HOLD) begin
      idle_addr_r <= idle_addr_r + pex_pkg::IDLE_STEP;
    end
  end

  // ==========================================================
  // Outputs
  // Fetch only after the entry cycle has written state
  assign VECTOR_FETCH_OUT = state_r == ST_VECT && !chain_fiq;
  assign EXC_BUSY_OUT = state_r != ST_RUN;
  assign IDLE_CYCLE_OUT = state_r == ST_RESET_HOLD;
  assign VECTOR_ADDR_OUT = vec_addr_r;
  assign IDLE_ADDR_OUT = idle_addr_r;
  assign CURRENT_STATUS_OUT = csr_r;
  assign SUPERVISOR_LINK_OUT = link_r[pex_pkg::BANK_SVC];
  assign SUPERVISOR_SAVED_OUT = saved_r[pex_pkg::BANK_SVC];
  assign ABORT_LINK_OUT = link_r[pex_pkg::BANK_ABT];
  assign ABORT_SAVED_OUT = saved_r[pex_pkg::BANK_ABT];
  assign UNDEFINED_LINK_OUT = link_r[pex_pkg::BANK_UND];
  assign UNDEFINED_SAVED_OUT = saved_r[pex_pkg::BANK_UND];
  assign INTERRUPT_LINK_OUT = link_r[pex_pkg::BANK_IRQ];
  assign INTERRUPT_SAVED_OUT = saved_r[pex_pkg::BANK_IRQ];
  assign FAST_LINK_OUT = link_r[pex_pkg::BANK_FIQ];
  assign FAST_SAVED_OUT = saved_r[pex_pkg::BANK_FIQ];
  assign FAULT_STATUS_REG_OUT = fsr_r;
  assign FAULT_ADDRESS_REG_OUT = far_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_take(pex_pkg::pex_exc_t e);
    take_exc && exc_sel == e && rst_pin_r ##1 state_r == ST_ENTRY;
  endsequence

  sequence s_entry(pex_pkg::pex_exc_t e);
    state_r == ST_ENTRY && exc_r == e && rst_pin_r;
  endsequence

  property p_irq_vector;
    s_entry(pex_pkg::EXC_IRQ) |=> VECTOR_ADDR_OUT == pex_pkg::VEC_IRQ;
  endproperty
  a_irq_vector: assert property (p_irq_vector)
    else $error("normal interrupt vector wrong");

  property p_fault_cause;
    $changed(far_r) |-> $past(abort_now);
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("fault address changed without abort");

  property p_tag_flush;
    FLUSH_IN && !FETCH_DONE_IN && rst_pin_r |=> tag_r == '0;
  endproperty
  a_tag_flush: assert property (p_tag_flush)
    else $error("flush left a prefetch tag");

  property p_swap_abort;
    aborted && INSTR_CLASS_IN == pex_pkg::CLS_SWAP |->
      !BASE_WB_ALLOW_OUT && REG_WRITE_BLOCK_OUT;
  endproperty
  a_swap_abort: assert property (p_swap_abort)
    else $error("aborted swap allowed a write");

  property p_block_abort;
    aborted && INSTR_CLASS_IN != pex_pkg::CLS_SWAP &&
      INSTR_CLASS_IN != pex_pkg::CLS_OTHER |->
      BASE_WB_ALLOW_OUT && REG_WRITE_BLOCK_OUT;
  endproperty
  a_block_abort: assert property (p_block_abort)
    else $error("aborted transfer write control wrong");

  property p_fault_capture;
    abort_now && TRANSLATE_EN_IN |=>
      fsr_r == {$past(FAULT_DOMAIN_IN), $past(FAULT_STATUS_IN)} &&
      far_r == $past(FAULT_VADDR_IN);
  endproperty
  a_fault_capture: assert property (p_fault_capture)
    else $error("fault registers not captured");

  property p_dabt_link;
    s_take(pex_pkg::EXC_DABT) |=>
      ABORT_LINK_OUT == $past(dabt_addr_r, 2) + pex_pkg::LINK_ADD_DATA &&
      ABORT_SAVED_OUT == $past(csr_r);
  endproperty
  a_dabt_link: assert property (p_dabt_link)
    else $error("data abort link or saved status wrong");

  property p_abt_mode;
    s_entry(pex_pkg::EXC_PABT) or s_entry(pex_pkg::EXC_DABT) |=>
      csr_r[4:0] == pex_pkg::MODE_ABT && csr_r[pex_pkg::CSR_I_BIT];
  endproperty
  a_abt_mode: assert property (p_abt_mode)
    else $error("abort entry mode or mask wrong");

  property p_swi_entry;
    s_take(pex_pkg::EXC_SWI) |=>
      SUPERVISOR_LINK_OUT ==
        $past(INSTR_ADDR_IN, 2) + pex_pkg::LINK_ADD_SHORT &&
      csr_r[4:0] == pex_pkg::MODE_SVC ##0 VECTOR_ADDR_OUT == pex_pkg::VEC_SWI;
  endproperty
  a_swi_entry: assert property (p_swi_entry)
    else $error("software interrupt entry wrong");

  property p_undef_take;
    take_exc && rst_pin_r && INSTR_COPROC_IN && !COPROC_INTERNAL_XFER_IN &&
      !dabt_pend_r && !fiq_go && !irq_go && !tag_r[PIPE_DEPTH-1] |=>
      exc_r == pex_pkg::EXC_UND ##1 csr_r[4:0] == pex_pkg::MODE_UND;
  endproperty
  a_undef_take: assert property (p_undef_take)
    else $error("coprocessor instruction did not trap");

  property p_no_reserved;
    VECTOR_FETCH_OUT |-> VECTOR_ADDR_OUT != pex_pkg::VEC_RESERVED;
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("reserved vector fetched");

  property p_dabt_first;
    take_exc && dabt_pend_r && rst_pin_r |=> exc_r == pex_pkg::EXC_DABT;
  endproperty
  a_dabt_first: assert property (p_dabt_first)
    else $error("data abort lost priority");

  property p_chain;
    chain_fiq && rst_pin_r |=> s_entry(pex_pkg::EXC_FIQ) ##1
      FAST_LINK_OUT == pex_pkg::VEC_DABT + pex_pkg::LINK_ADD_SHORT &&
      csr_r[4:0] == pex_pkg::MODE_FIQ && csr_r[pex_pkg::CSR_F_BIT];
  endproperty
  a_chain: assert property (p_chain)
    else $error("fast entry after data abort missing");

  property p_idle_walk;
    state_r == ST_RESET_HOLD ##1 state_r == ST_RESET_HOLD |->
      IDLE_CYCLE_OUT && IDLE_ADDR_OUT == $past(IDLE_ADDR_OUT) +
      pex_pkg::IDLE_STEP;
  endproperty
  a_idle_walk: assert property (p_idle_walk)
    else $error("idle address not stepping");

  property p_reset_fetch;
    $rose(rst_pin_r) ##1 rst_pin_r ##1 rst_pin_r |->
      VECTOR_FETCH_OUT && VECTOR_ADDR_OUT == pex_pkg::VEC_RESET &&
      csr_r[4:0] == pex_pkg::MODE_SVC && csr_r[pex_pkg::CSR_I_BIT] &&
      csr_r[pex_pkg::CSR_F_BIT];
  endproperty
  a_reset_fetch: assert property (p_reset_fetch)
    else $error("reset release fetch wrong");

  property p_entry_first;
    VECTOR_FETCH_OUT |-> $past(state_r) == ST_ENTRY;
  endproperty
  a_entry_first: assert property (p_entry_first)
    else $error("vector fetched before entry");

endmodule : pex_exception_entry

// File: pex_pkg.sv
// Constants and types shared by the exception entry unit.
// Assumes a 32-bit core with a 32-bit status word.
package pex_pkg;

  // ==========================================================
  // Vector byte addresses
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
  localparam logic [31:0] VEC_SWI = 32'h0000_0008;
  localparam logic [31:0] VEC_PABT = 32'h0000_000C;
  localparam logic [31:0] VEC_DABT = 32'h0000_0010;
  localparam logic [31:0] VEC_RESERVED = 32'h0000_0014;
  localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
  localparam logic [31:0] VEC_FIQ = 32'h0000_001C;

  // ==========================================================
  // Status word layout and mode codes
  localparam int CSR_I_BIT = 7;
  localparam int CSR_F_BIT = 6;
  localparam int CSR_MODE_LSB = 0;
  localparam int CSR_MODE_W = 5;
  localparam logic [31:0] CSR_RESET = 32'h0000_00D3;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1B;

  // ==========================================================
  // Return address offsets and idle address step
  localparam logic [31:0] LINK_ADD_SHORT = 32'h0000_0004;
  localparam logic [31:0] LINK_ADD_DATA = 32'h0000_0008;
  localparam logic [31:0] IDLE_STEP = 32'h0000_0004;

  // ==========================================================
  // Fault capture widths, instruction classes, banks
  localparam int FS_W = 4;
  localparam int DOMAIN_W = 4;
  localparam logic [1:0] CLS_OTHER = 2'h0;
  localparam logic [1:0] CLS_SINGLE = 2'h1;
  localparam logic [1:0] CLS_SWAP = 2'h2;
  localparam logic [1:0] CLS_BLOCK = 2'h3;
  localparam int NUM_BANKS = 5;
  localparam logic [2:0] BANK_SVC = 3'h0;
  localparam logic [2:0] BANK_ABT = 3'h1;
  localparam logic [2:0] BANK_UND = 3'h2;
  localparam logic [2:0] BANK_IRQ = 3'h3;
  localparam logic [2:0] BANK_FIQ = 3'h4;

  typedef enum logic [2:0] {
    EXC_NONE, EXC_RESET, EXC_DABT, EXC_FIQ, EXC_IRQ, EXC_PABT, EXC_UND,
    EXC_SWI
  } pex_exc_t;

  function automatic logic [31:0] pex_vector(input pex_exc_t e);
    case (e)
      EXC_UND: pex_vector = VEC_UNDEF;
      EXC_SWI: pex_vector = VEC_SWI;
      EXC_PABT: pex_vector = VEC_PABT;
      EXC_DABT: pex_vector = VEC_DABT;
      EXC_IRQ: pex_vector = VEC_IRQ;
      EXC_FIQ: pex_vector = VEC_FIQ;
      default: pex_vector = VEC_RESET;
    endcase
  endfunction : pex_vector

  function automatic logic [4:0] pex_mode(input pex_exc_t e);
    case (e)
      EXC_UND: pex_mode = MODE_UND;
      EXC_PABT, EXC_DABT: pex_mode = MODE_ABT;
      EXC_IRQ: pex_mode = MODE_IRQ;
      EXC_FIQ: pex_mode = MODE_FIQ;
      default: pex_mode = MODE_SVC;
    endcase
  endfunction : pex_mode

  function automatic logic [2:0] pex_bank(input pex_exc_t e);
    case (e)
      EXC_UND: pex_bank = BANK_UND;
      EXC_PABT, EXC_DABT: pex_bank = BANK_ABT;
      EXC_IRQ: pex_bank = BANK_IRQ;
      EXC_FIQ: pex_bank = BANK_FIQ;
      default: pex_bank = BANK_SVC;
    endcase
  endfunction : pex_bank

endpackage : pex_pkg

// File: pex_partner.sv
// Far side model: reset controller, interrupt sources, abort logic.
// Assumes the bench raises requests just after rising edges.
`timescale 1ns/1ps
module pex_partner (
  // Requests from bench
  input wire logic rst_req_in,
  input wire logic fiq_req_in,
  input wire logic irq_req_in,
  input wire logic abt_req_in,
  input wire logic data_in,
  // Device pins
  output logic reset_n_out,
  output logic fiq_n_out,
  output logic irq_n_out,
  output logic mem_cycle_out,
  output logic data_access_out,
  output logic ext_abort_out
);
  // ==========================================
  // Pin levels
  // reset and interrupt levels held low
  assign reset_n_out = !rst_req_in;
  assign fiq_n_out = !fiq_req_in;
  assign irq_n_out = !irq_req_in;
  assign mem_cycle_out = abt_req_in;
  assign data_access_out = data_in;
  assign ext_abort_out = abt_req_in;
endmodule : pex_partner

// File: pex_exception_entry_tb_top.sv
// Bench for the exception entry unit: reset, then table of entries,
// abort chaining and priority. Assumes pex_pkg and the partner model.
`timescale 1ns/1ps
module pex_exception_entry_tb_top;
  typedef struct packed {
    logic [4:0] dec;
    logic [7:0] vec;
    logic [4:0] md;
  } pex_row_t;
  // Decode bits: swi, unknown, coproc, irq, fiq
  pex_row_t rows [5] = '{'{5'h10, 8'h08, 5'h13}, '{5'h08, 8'h04, 5'h1B},
    '{5'h04, 8'h04, 5'h1B}, '{5'h02, 8'h18, 5'h12}, '{5'h01, 8'h1C, 5'h11}};
  logic clk = 1'b0, rst_b = 1'b0, rr = 1'b1, fr = 1'b0, ir = 1'b0;
  logic ar = 1'b0, dr = 1'b0, ex = 1'b0, unk = 1'b0, cop = 1'b0;
  logic software_interrupt_instruction = 1'b0, cw = 1'b0, te = 1'b0, fe = 1'b0, fx = 1'b0;
  logic [3:0] fs = 4'h0, fd = 4'h0;
  logic [31:0] ad = 32'h0, wd = 32'h0, fva = 32'h0, t;
  wire pn, fn, inn, mc, da, ea, vf, idle;
  wire [31:0] va, ia, st, sl, al, asv, ul, il, fl, fad;
  wire [7:0] fault_status_register;
  int failures = 0, check_count = 0, n;
  always #20 clk = ~clk;
  pex_partner PM (.rst_req_in(rr), .fiq_req_in(fr), .irq_req_in(ir),
    .abt_req_in(ar), .data_in(dr), .reset_n_out(pn), .fiq_n_out(fn),
    .irq_n_out(inn), .mem_cycle_out(mc), .data_access_out(da),
    .ext_abort_out(ea));
  pex_exception_entry DUT (.CLOCK_IN(clk), .RST_B_IN(rst_b),
    .RESET_IN_N_IN(pn), .FAST_INTERRUPT_IN_N_IN(fn),
    .NORMAL_INTERRUPT_IN_N_IN(inn), .MEM_CYCLE_IN(mc),
    .DATA_ACCESS_IN(da), .FETCH_DONE_IN(fe), .MMU_ABORT_IN(1'b0),
    .EXT_ABORT_IN(ea), .TRANSLATE_EN_IN(te), .FAULT_STATUS_IN(fs),
    .FAULT_DOMAIN_IN(fd), .FAULT_VADDR_IN(fva), .FLUSH_IN(fx),
    .EXEC_START_IN(ex), .INSTR_ADDR_IN(ad), .INSTR_CLASS_IN(2'h1),
    .INSTR_UNKNOWN_IN(unk), .INSTR_COPROC_IN(cop),
    .COPROC_INTERNAL_XFER_IN(1'b0), .SWI_INSTR_IN(software_interrupt_instruction), .CSR_WR_IN(cw),
    .CSR_WDATA_IN(wd), .EXC_BUSY_OUT(), .VECTOR_FETCH_OUT(vf),
    .VECTOR_ADDR_OUT(va), .IDLE_CYCLE_OUT(idle), .IDLE_ADDR_OUT(ia),
    .REG_WRITE_BLOCK_OUT(), .BASE_WB_ALLOW_OUT(), .CURRENT_STATUS_OUT(st),
    .SUPERVISOR_LINK_OUT(sl), .SUPERVISOR_SAVED_OUT(), .ABORT_LINK_OUT(al),
    .ABORT_SAVED_OUT(asv), .UNDEFINED_LINK_OUT(ul), .UNDEFINED_SAVED_OUT(),
    .INTERRUPT_LINK_OUT(il), .INTERRUPT_SAVED_OUT(), .FAST_LINK_OUT(fl),
    .FAST_SAVED_OUT(), .FAULT_STATUS_REG_OUT(fault_status_register),
    .FAULT_ADDRESS_REG_OUT(fad));
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [31:0] lk(input logic [4:0] m);
    case (m)
      5'h13: lk = sl;
      5'h1B: lk = ul;
      5'h12: lk = il;
      default: lk = fl;
    endcase
  endfunction : lk
  // Decode drops one edge after the boundary; pin requests stay held
  // so that a chained fast entry still sees its request
  task automatic go(input logic [31:0] a);
    @(posedge clk);
    ex <= 1'b1;
    ad <= a;
    @(posedge clk);
    ex <= 1'b0;
    {software_interrupt_instruction, unk, cop} <= 3'h0;
    #1;
    for (n = 0; vf !== 1'b1 && n < 20; n++) @(posedge clk) #1;
    chk("vec_fetch", {31'h0, vf}, 32'h1);
  endtask : go
  task automatic end_of_test();
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    end_of_test();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    #1 t = ia;
    chk("idle", {31'h0, idle}, 32'h1);
    @(posedge clk) #1 chk("idle_addr", ia, t + 32'h4);
    @(posedge clk) rr <= 1'b0;
    #1;
    for (n = 0; vf !== 1'b1 && n < 20; n++) @(posedge clk) #1;
    chk("reset_lat", n, 32'h4);
    chk("reset_vec", va, pex_pkg::VEC_RESET);
    chk("reset_st", st & 32'hDF, 32'hD3);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      cw <= 1'b1;
      wd <= 32'h10;
      {software_interrupt_instruction, unk, cop, ir, fr} <= rows[i].dec;
      @(posedge clk) cw <= 1'b0;
      go(32'h100 + 32'(i) * 32'h4);
      {ir, fr} <= 2'h0;
      chk("vec", va, {24'h0, rows[i].vec});
      chk("status", st & 32'hDF, {24'h0, 1'b1, rows[i].md == 5'h11, 1'b0,
        rows[i].md});
      chk("link", lk(rows[i].md), ad + 32'h4);
    end
    // Prefetch abort tags a fetch that reaches the head one fetch on
    @(posedge clk);
    {ar, fe} <= 2'h3;
    @(posedge clk) ar <= 1'b0;
    @(posedge clk) fe <= 1'b0;
    go(32'h180);
    chk("pabt_vec", va, pex_pkg::VEC_PABT);
    chk("pabt_link", al, 32'h184);
    @(posedge clk) fx <= 1'b1;
    @(posedge clk) fx <= 1'b0;
    // Data abort, fast and normal requests all at once
    @(posedge clk);
    {cw, ar, dr, te, fr, ir} <= 6'h3F;
    wd <= 32'h10;
    {fd, fs} <= 8'hA5;
    fva <= 32'hBEEF_0120;
    t = ad;
    @(posedge clk);
    {cw, ar} <= 2'h0;
    go(32'h200);
    chk("chain_vec", va, pex_pkg::VEC_FIQ);
    chk("abt_link", al, t + 32'h8);
    chk("abt_saved", asv, 32'h10);
    chk("fiq_link", fl, 32'h14);
    chk("fsr", {24'h0, fault_status_register}, 32'hA5);
    chk("fault_addr", fad, 32'hBEEF_0120);
    end_of_test();
  end
endmodule : pex_exception_entry_tb_top
